// >>> core/cmr_pkg.sv
package cmr_pkg;
  // Device register port widths
  localparam int AW = 7;
  localparam int DW = 8;

  // Device register locations
  localparam logic [6:0] REG_PAGE     = 7'h00;
  localparam logic [6:0] REG_ADC_PATH = 7'h6B;
  localparam logic [6:0] REG_BYPASS   = 7'h6C;
  localparam logic [6:0] REG_DAC_TRIM = 7'h6D;
  localparam logic [6:0] REG_RSVD_LO  = 7'h6E;
  localparam logic [6:0] REG_RSVD_HI  = 7'h7F;

  // Field positions
  localparam int HPF_L_BIT     = 7;
  localparam int HPF_R_BIT     = 6;
  localparam int DECIM_HI      = 5;
  localparam int DECIM_LO      = 4;
  localparam int PROG_FILT_BIT = 3;
  localparam int HANG_DIS_BIT  = 2;
  localparam int HANG_STAT_BIT = 0;
  localparam int BYP_L2R_BIT   = 6;
  localparam int BYP_L1R_BIT   = 4;
  localparam int BYP_L2L_BIT   = 2;
  localparam int BYP_L1L_BIT   = 0;
  localparam int DAC_CUR_HI    = 7;
  localparam int DAC_CUR_LO    = 6;
  localparam int PAGE_BIT      = 0;

  // Writable bits per register, reset value
  localparam logic [7:0] ADC_PATH_WMASK = 8'hFC;
  localparam logic [7:0] BYPASS_WMASK   = 8'h55;
  localparam logic [7:0] DAC_TRIM_WMASK = 8'hC0;
  localparam logic [7:0] PAGE_WMASK     = 8'h01;
  localparam logic [7:0] BYTE_RST       = 8'h00;

  // Decimation source and DAC current codes
  localparam logic [1:0] DECIM_DMIC_BOTH = 2'h0;
  localparam logic [1:0] DECIM_DL_AR     = 2'h1;
  localparam logic [1:0] DECIM_AL_DR     = 2'h2;
  localparam logic [1:0] DECIM_AMIC_BOTH = 2'h3;
  localparam logic [1:0] DAC_CUR_50      = 2'h1;
  localparam logic [1:0] DAC_CUR_100     = 2'h3;

  // Controller APB map and fields
  localparam logic [7:0] APB_CMD      = 8'h00;
  localparam logic [7:0] APB_STAT     = 8'h04;
  localparam logic [7:0] APB_INT_STAT = 8'h08;
  localparam logic [7:0] APB_INT_MASK = 8'h0C;
  localparam int CMD_DATA_LO   = 8;
  localparam int CMD_WRITE_BIT = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_PAGE_BIT = 1;
  localparam int STAT_DATA_LO  = 8;
  localparam int INT_DONE_BIT  = 0;
  localparam int INT_REF_BIT   = 1;
  localparam int INT_W         = 2;
endpackage

// >>> core/cmr_bus_if.sv
interface cmr_bus_if;
  import cmr_pkg::*;
  // Register access request from the controller
  logic          req;
  logic          we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  // Answer from the device
  logic [DW-1:0] rdata;
  logic          ack;

  modport dev  (input req, we, addr, wdata, output rdata, ack);
  modport host (output req, we, addr, wdata, input rdata, ack);
endinterface

// >>> core/cmr_device.sv
// Operation
// (R1) Left high-pass uses programmable coefficients when bit set
// (R2) Right high-pass uses programmable coefficients when bit set
// (R3) Decimation field picks digital or analog microphones
// (R4) Programmable filter attaches only with both DACs down
// (R5) Bus-condition bit enables or disables hang detection
// (R6) Hang status reads one, cleared by register read
// (R7) Right bypass bits switch inputs to right output
// (R8) Left bypass bits switch inputs to left output
// (R9) Host writes zero to odd bypass bits
// (R10) Host avoids two bypasses onto one output
// (R11) DAC current field: default, +50%, reserved, +100%
// (R12) Host writes zero to low DAC trim bits
// (R13) Locations 110 to 127 read zero, unwritten
// (R14) Page bit selects active page
// (R15) Page register at zero on both pages
// (R16) Host reads page back after writing it
// (R17) Host writes zero to other page bits
// (R18) New hang beats a clearing read
module cmr_device
  import cmr_pkg::*;
(
  // Clock, reset, enable
  input  wire logic CLOCK,
  input  wire logic RESETN,
  input  wire logic CE,
  // Register port
  cmr_bus_if.dev    BUS,
  // Status from the codec
  input  wire logic HPF_ENABLE,
  input  wire logic DACS_POWERED_DOWN,
  input  wire logic BUS_HANG,
  // Filter and source steering
  output logic      HPF_LEFT_PROG,
  output logic      HPF_RIGHT_PROG,
  output logic      LEFT_DMIC_SEL,
  output logic      RIGHT_DMIC_SEL,
  output logic      PROG_FILTER_ATTACH,
  // Hang detector
  output logic      HANG_DETECT_EN,
  output logic      BUS_ERROR_CLEAR,
  // Bypass switches
  output logic      SECOND_RIGHT_LINE_INPUT_SW,
  output logic      FIRST_RIGHT_LINE_INPUT_SW,
  output logic      SECOND_LEFT_LINE_INPUT_SW,
  output logic      FIRST_LEFT_LINE_INPUT_SW,
  // DAC reference current and page
  output logic      DAC_REF_BOOST50,
  output logic      DAC_REF_BOOST100,
  output logic      ACTIVE_PAGE
);

  localparam int NSYNC = 2;

  logic [NSYNC-1:0] sync_in;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic             dacs_down;
  logic             hang_seen;
  logic             page_r;
  logic [DW-1:0]    adc_path_r;
  logic [DW-1:0]    bypass_r;
  logic [DW-1:0]    dac_trim_r;
  logic             hang_stat_r;
  logic [DW-1:0]    rdata_r;
  logic [DW-1:0]    rd_nxt;
  logic             ack_r;
  logic             on_page0;
  logic             wr;
  logic             rd;
  logic             hang_evt;
  logic [1:0]       decim;
  logic [1:0]       dac_cur;

  assign sync_in   = {BUS_HANG, DACS_POWERED_DOWN};
  assign dacs_down = sync2_r[0];
  assign hang_seen = sync2_r[1];

  // Two-stage synchronisers for the DAC power-down and bus hang inputs
  generate
    for (genvar i = 0; i < NSYNC; i++)
    begin : g_sync
      always_ff @(posedge CLOCK or negedge RESETN)
      begin
        if (!RESETN)
        begin
          sync1_r[i] <= 1'b0;
          sync2_r[i] <= 1'b0;
        end
        else if (CE)
        begin
          sync1_r[i] <= sync_in[i];
          sync2_r[i] <= sync1_r[i];
        end
      end
    end
  endgenerate

  // Access decode; page register sits at zero on either page
  assign on_page0 = (page_r == 1'b0);
  assign wr       = BUS.req && BUS.we;
  assign rd       = BUS.req && !BUS.we;

  // Page select register
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      page_r <= 1'b0;
    else if (CE && wr && BUS.addr == REG_PAGE) // R15
      page_r <= BUS.wdata[PAGE_BIT]; // R14
  end

  // Page 0 control registers; only defined bits are stored
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      adc_path_r <= BYTE_RST;
      bypass_r   <= BYTE_RST;
      dac_trim_r <= BYTE_RST;
    end
    else if (CE && wr && on_page0)
    begin
      unique case (BUS.addr)
        REG_ADC_PATH: adc_path_r <= BUS.wdata & ADC_PATH_WMASK;
        REG_BYPASS:   bypass_r   <= BUS.wdata & BYPASS_WMASK;
        REG_DAC_TRIM: dac_trim_r <= BUS.wdata & DAC_TRIM_WMASK;
        default:      ; // Reserved block and others ignore writes
      endcase
    end
  end

  // Hang seen while detection is on, rising edge only
  logic hang_d_r;
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      hang_d_r <= 1'b0;
    else if (CE)
      hang_d_r <= hang_seen;
  end
  assign hang_evt = hang_seen && !hang_d_r && !adc_path_r[HANG_DIS_BIT]; // R5

  // Sticky hang status; a new hang wins over a clearing read
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      hang_stat_r <= 1'b0;
    else if (CE)
    begin
      if (hang_evt)
        hang_stat_r <= 1'b1; // R6 R18
      else if (rd && on_page0 && BUS.addr == REG_ADC_PATH)
        hang_stat_r <= 1'b0; // R6
    end
  end

  // Read mux; reserved block and page 1 locations read zero
  always_comb
  begin
    rd_nxt = BYTE_RST;
    if (BUS.addr == REG_PAGE)
      rd_nxt[PAGE_BIT] = page_r; // R15
    else if (on_page0)
    begin
      unique case (BUS.addr)
        REG_ADC_PATH:
        begin
          rd_nxt = adc_path_r;
          rd_nxt[HANG_STAT_BIT] = hang_stat_r; // R6
        end
        REG_BYPASS:   rd_nxt = bypass_r;
        REG_DAC_TRIM: rd_nxt = dac_trim_r;
        default:      rd_nxt = BYTE_RST; // R13
      endcase
    end
  end

  // Answer one cycle after each request
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rdata_r <= BYTE_RST;
      ack_r   <= 1'b0;
    end
    else if (CE)
    begin
      ack_r <= BUS.req;
      if (rd)
        rdata_r <= rd_nxt;
    end
  end

  assign BUS.rdata = rdata_r;
  assign BUS.ack   = ack_r;

  assign decim   = adc_path_r[DECIM_HI:DECIM_LO];
  assign dac_cur = dac_trim_r[DAC_CUR_HI:DAC_CUR_LO];

  // Registered steering outputs
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      HPF_LEFT_PROG              <= 1'b0;
      HPF_RIGHT_PROG             <= 1'b0;
      LEFT_DMIC_SEL              <= 1'b0;
      RIGHT_DMIC_SEL             <= 1'b0;
      PROG_FILTER_ATTACH         <= 1'b0;
      HANG_DETECT_EN             <= 1'b0;
      BUS_ERROR_CLEAR            <= 1'b0;
      SECOND_RIGHT_LINE_INPUT_SW <= 1'b0;
      FIRST_RIGHT_LINE_INPUT_SW  <= 1'b0;
      SECOND_LEFT_LINE_INPUT_SW  <= 1'b0;
      FIRST_LEFT_LINE_INPUT_SW   <= 1'b0;
      DAC_REF_BOOST50            <= 1'b0;
      DAC_REF_BOOST100           <= 1'b0;
      ACTIVE_PAGE                <= 1'b0;
    end
    else if (CE)
    begin
      HPF_LEFT_PROG  <= HPF_ENABLE && adc_path_r[HPF_L_BIT]; // R1
      HPF_RIGHT_PROG <= HPF_ENABLE && adc_path_r[HPF_R_BIT]; // R2
      LEFT_DMIC_SEL  <= (decim == DECIM_DMIC_BOTH)
                        || (decim == DECIM_DL_AR); // R3
      RIGHT_DMIC_SEL <= (decim == DECIM_DMIC_BOTH)
                        || (decim == DECIM_AL_DR); // R3
      PROG_FILTER_ATTACH <= adc_path_r[PROG_FILT_BIT] && dacs_down; // R4
      HANG_DETECT_EN  <= !adc_path_r[HANG_DIS_BIT]; // R5
      BUS_ERROR_CLEAR <= hang_evt; // R5
      SECOND_RIGHT_LINE_INPUT_SW <= bypass_r[BYP_L2R_BIT]; // R7
      FIRST_RIGHT_LINE_INPUT_SW  <= bypass_r[BYP_L1R_BIT]; // R7
      SECOND_LEFT_LINE_INPUT_SW  <= bypass_r[BYP_L2L_BIT]; // R8
      FIRST_LEFT_LINE_INPUT_SW   <= bypass_r[BYP_L1L_BIT]; // R8
      DAC_REF_BOOST50  <= (dac_cur == DAC_CUR_50); // R11
      DAC_REF_BOOST100 <= (dac_cur == DAC_CUR_100); // R11
      ACTIVE_PAGE      <= page_r; // R14
    end
  end

endmodule

// >>> core/cmr_host.sv
module cmr_host
  import cmr_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  input  wire logic        CE,
  // APB slave
  input  wire logic [7:0]  PADDR,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Interrupt
  output logic             IRQ,
  // Device register port
  cmr_bus_if.host          BUS
);

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_REQ  = 2'b01,
    ST_WAIT = 2'b10,
    ST_BACK = 2'b11
  } cmr_state_t;

  cmr_state_t        state_r;
  logic              we_r;
  logic [AW-1:0]     addr_r;
  logic [DW-1:0]     wdata_r;
  logic [DW-1:0]     rdata_r;
  logic              page_r;
  logic [INT_W-1:0]  int_stat_r;
  logic [INT_W-1:0]  int_mask_r;
  logic [INT_W-1:0]  int_set;
  logic              apb_wr;
  logic              cmd_go;
  logic              refuse;
  logic [AW-1:0]     c_addr;
  logic [DW-1:0]     c_data;
  logic [DW-1:0]     c_mask;
  logic              c_we;

  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign cmd_go = apb_wr && PADDR == APB_CMD && state_r == ST_IDLE;
  assign c_addr = PWDATA[AW-1:0];
  assign c_we   = PWDATA[CMD_WRITE_BIT];

  // Reserved page, bypass and DAC trim bits forced to zero on writes
  always_comb
  begin
    c_mask = 8'hFF;
    if (c_addr == REG_PAGE)
      c_mask = PAGE_WMASK; // R17
    else if (!page_r && c_addr == REG_BYPASS)
      c_mask = BYPASS_WMASK; // R9
    else if (!page_r && c_addr == REG_DAC_TRIM)
      c_mask = DAC_TRIM_WMASK; // R12
    c_data = PWDATA[CMD_DATA_LO +: DW] & c_mask;
  end

  // Refuse writes to reserved block and shorting bypass pairs
  always_comb
  begin
    refuse = 1'b0;
    if (c_we && !page_r && c_addr >= REG_RSVD_LO && c_addr <= REG_RSVD_HI)
      refuse = 1'b1; // R13
    if (c_we && !page_r && c_addr == REG_BYPASS
        && ((c_data[BYP_L2R_BIT] && c_data[BYP_L1R_BIT])
        || (c_data[BYP_L2L_BIT] && c_data[BYP_L1L_BIT])))
      refuse = 1'b1; // R10
  end

  // Transfer sequencer; page writes are read back
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_r <= ST_IDLE;
      we_r    <= 1'b0;
      addr_r  <= REG_PAGE;
      wdata_r <= BYTE_RST;
      rdata_r <= BYTE_RST;
      page_r  <= 1'b0;
    end
    else if (CE)
    begin
      unique case (state_r)
        ST_IDLE:
          if (cmd_go && !refuse)
          begin
            we_r    <= c_we;
            addr_r  <= c_addr;
            wdata_r <= c_data;
            state_r <= ST_REQ;
          end
        ST_REQ:
          state_r <= ST_WAIT;
        ST_WAIT:
          if (BUS.ack)
          begin
            if (!we_r)
              rdata_r <= BUS.rdata;
            if (!we_r && addr_r == REG_PAGE)
              page_r <= BUS.rdata[PAGE_BIT];
            if (we_r && addr_r == REG_PAGE)
            begin
              we_r    <= 1'b0; // R16
              state_r <= ST_BACK;
            end
            else
              state_r <= ST_IDLE;
          end
        ST_BACK:
          state_r <= ST_REQ;
      endcase
    end
  end

  assign BUS.req   = (state_r == ST_REQ);
  assign BUS.we    = we_r;
  assign BUS.addr  = addr_r;
  assign BUS.wdata = wdata_r;

  // Events: transfer finished, command refused
  assign int_set[INT_DONE_BIT] = CE && state_r == ST_WAIT && BUS.ack
                                 && !(we_r && addr_r == REG_PAGE);
  assign int_set[INT_REF_BIT]  = CE && cmd_go && refuse;

  // Sticky status with write-one-to-clear; set wins
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      int_stat_r <= '0;
      int_mask_r <= '0;
    end
    else if (CE)
    begin
      if (apb_wr && PADDR == APB_INT_MASK)
        int_mask_r <= PWDATA[INT_W-1:0];
      if (apb_wr && PADDR == APB_INT_STAT)
        int_stat_r <= (int_stat_r & ~PWDATA[INT_W-1:0]) | int_set;
      else
        int_stat_r <= int_stat_r | int_set;
    end
  end

  assign IRQ = |(int_stat_r & int_mask_r);

  // Read data captured in the setup cycle
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      PRDATA <= 32'h0000_0000;
    else if (CE && PSEL && !PENABLE)
    begin
      PRDATA <= 32'h0000_0000;
      unique case (PADDR)
        APB_CMD:
        begin
          PRDATA[AW-1:0]              <= addr_r;
          PRDATA[CMD_DATA_LO +: DW]   <= wdata_r;
          PRDATA[CMD_WRITE_BIT]       <= we_r;
        end
        APB_STAT:
        begin
          PRDATA[STAT_BUSY_BIT]       <= (state_r != ST_IDLE);
          PRDATA[STAT_PAGE_BIT]       <= page_r;
          PRDATA[STAT_DATA_LO +: DW]  <= rdata_r;
        end
        APB_INT_STAT: PRDATA[INT_W-1:0] <= int_stat_r;
        APB_INT_MASK: PRDATA[INT_W-1:0] <= int_mask_r;
        default:      PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  assign PREADY  = 1'b1;
  assign PSLVERR = 1'b0;

endmodule

// >>> test/cmr_bus_monitor.sv
module cmr_bus_monitor
  import cmr_pkg::*;
(
  // Clock, reset, enable
  input wire logic          CLOCK,
  input wire logic          RESETN,
  input wire logic          CE,
  // Register port as seen on the wire
  input wire logic          req,
  input wire logic          we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic [DW-1:0] rdata,
  input wire logic          ack
);
  timeunit 1ns;
  timeprecision 1ps;

  logic page_r;
  logic rd;
  logic wr;

  // Qualified read and write requests
  assign rd = req && CE && !we;
  assign wr = req && CE && we;

  // Active page as set by writes on the wire
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      page_r <= 1'b0;
    else if (wr && addr == REG_PAGE)
      page_r <= wdata[PAGE_BIT];
  end

  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);

  // Page write acknowledged, then its readback
  sequence page_wr_s;
    wr && addr == REG_PAGE ##1 ack;
  endsequence
  sequence page_rd_s;
    ##[1:4] rd && addr == REG_PAGE;
  endsequence

  ack_follows_a:
    assert property (req && CE |=> ack && !req)
    else $error("no acknowledge after request");
  ack_cause_a:
    assert property (ack |-> $past(req))
    else $error("acknowledge without request");
  req_spacing_a:
    assert property (req |=> !req [*2])
    else $error("requests too close together");
  rsvd_wr_a:
    assert property (wr && !page_r |-> addr < REG_RSVD_LO)
    else $error("write to reserved location");
  bypass_wr_a:
    assert property (wr && !page_r && addr == REG_BYPASS
      |-> (wdata & ~BYPASS_WMASK) == 8'h00 && !(wdata[6] && wdata[4])
        && !(wdata[2] && wdata[0]))
    else $error("bad bypass write");
  trim_wr_a:
    assert property (wr && !page_r && addr == REG_DAC_TRIM
      |-> wdata[5:0] == 6'h00)
    else $error("reserved trim bits written");
  page_bits_a:
    assert property (wr && addr == REG_PAGE |-> wdata[7:1] == 7'h00)
    else $error("reserved page bits written");
  page_check_a:
    assert property (page_wr_s |-> page_rd_s)
    else $error("page write not read back");
  page_rd_a:
    assert property (rd && addr == REG_PAGE
      |=> ack && rdata == {7'h00, page_r})
    else $error("page readback wrong");
  rsvd_rd_a:
    assert property (rd && addr != REG_PAGE
      && (page_r || addr >= REG_RSVD_LO) |=> rdata == 8'h00)
    else $error("reserved location not zero");
endmodule

// >>> test/tb_top.sv
module tb_top
  import cmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        irq;
  logic        pslverr;
  logic        noted = 1'b0;
  logic        hpf_en = 1'b0;
  logic        dacs_dn = 1'b0;
  logic        hang = 1'b0;
  logic [13:0] dout;
  logic [63:0] exp_q[$];
  int          num_errors = 0;
  int          n_compared = 0;
  int          cyc = 0;

  cmr_bus_if u_cmr_bus_if ();

  cmr_host u_cmr_host (
    .CLOCK(clk), .RESETN(rstn), .CE(ce), .PADDR(paddr), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq),
    .BUS(u_cmr_bus_if.host)
  );

  cmr_device u_cmr_device (
    .CLOCK(clk), .RESETN(rstn), .CE(ce), .BUS(u_cmr_bus_if.dev),
    .HPF_ENABLE(hpf_en), .DACS_POWERED_DOWN(dacs_dn), .BUS_HANG(hang),
    .HPF_LEFT_PROG(dout[13]), .HPF_RIGHT_PROG(dout[12]),
    .LEFT_DMIC_SEL(dout[11]), .RIGHT_DMIC_SEL(dout[10]),
    .PROG_FILTER_ATTACH(dout[9]), .HANG_DETECT_EN(dout[8]),
    .BUS_ERROR_CLEAR(dout[7]), .SECOND_RIGHT_LINE_INPUT_SW(dout[6]),
    .FIRST_RIGHT_LINE_INPUT_SW(dout[5]),
    .SECOND_LEFT_LINE_INPUT_SW(dout[4]),
    .FIRST_LEFT_LINE_INPUT_SW(dout[3]), .DAC_REF_BOOST50(dout[2]),
    .DAC_REF_BOOST100(dout[1]), .ACTIVE_PAGE(dout[0])
  );

  cmr_bus_monitor u_mon (
    .CLOCK(clk), .RESETN(rstn), .CE(ce), .req(u_cmr_bus_if.req),
    .we(u_cmr_bus_if.we), .addr(u_cmr_bus_if.addr),
    .wdata(u_cmr_bus_if.wdata), .rdata(u_cmr_bus_if.rdata),
    .ack(u_cmr_bus_if.ack)
  );

  // Clock and hang cut-off
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  // Match each noted read against the oldest expectation
  always @(posedge clk)
  begin
    if (psel && penable && pready)
    begin
      n_compared++;
      if (pslverr !== 1'b0)
      begin
        num_errors++;
        $display("unexpected at %0t: slave error", $time);
      end
    end
    if (psel && penable && pready && noted && exp_q.size() > 0)
    begin
      n_compared++;
      if ((prdata & exp_q[0][63:32]) !== exp_q[0][31:0])
      begin
        num_errors++;
        $display("unexpected at %0t: read %h", $time, prdata);
      end
      void'(exp_q.pop_front());
    end
  end

  task automatic wrap_up();
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want)
    begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, got, want);
    end
  endtask

  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic n,
                     output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    noted <= n;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] x);
    logic [31:0] q;
    exp_q.push_back({m, x});
    apb(1'b0, a, 32'h0, 1'b1, q);
  endtask

  // Device access through the command register, waits for idle
  task automatic dev(input logic w, input logic [6:0] a,
                     input logic [7:0] d);
    logic [31:0] q;
    apb(1'b1, APB_CMD, {15'h0, w, d, 1'b0, a}, 1'b0, q);
    do
      apb(1'b0, APB_STAT, 32'h0, 1'b0, q);
    while (q[STAT_BUSY_BIT] !== 1'b0);
    @(posedge clk);
  endtask

  task automatic devrd(input logic [6:0] a, input logic [7:0] x);
    dev(1'b0, a, 8'h00);
    rd(APB_STAT, 32'h0000FF00, {16'h0, x, 8'h00});
  endtask

  // Raise the hang line and count error-clear pulses
  task automatic hang_pulse(output int seen);
    seen = 0;
    @(posedge clk);
    hang <= 1'b1;
    repeat (12)
    begin
      @(posedge clk);
      seen += int'(dout[7] === 1'b1);
    end
    hang <= 1'b0;
  endtask

  initial
  begin
    logic [7:0]  v;
    logic [31:0] e;
    logic [31:0] q;
    logic [7:0]  byp [4];
    int          seen;
    byp = '{8'h41, 8'h14, 8'h44, 8'h11};
    void'($urandom(32'hD099));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    devrd(REG_ADC_PATH, 8'h00);
    devrd(REG_BYPASS, 8'h00);
    devrd(REG_DAC_TRIM, 8'h00);
    devrd(REG_RSVD_HI, 8'h00);
    // Every decimation code with random companions
    for (int c = 0; c < 4; c++)
    begin
      v = 8'($urandom());
      v[5:4] = 2'(c);
      hpf_en <= v[1];
      dacs_dn <= v[0];
      v[1:0] = 2'b00;
      dev(1'b1, REG_ADC_PATH, v);
      repeat (4) @(posedge clk);
      e = {26'h0, v[7] & hpf_en, v[6] & hpf_en, !v[5], !v[4],
           v[3] & dacs_dn, !v[2]};
      cmp(32'(dout[13:8]), e);
      devrd(REG_ADC_PATH, v);
    end
    // Legal bypass settings, one switch per side
    foreach (byp[i])
    begin
      dev(1'b1, REG_BYPASS, byp[i]);
      e = {28'h0, byp[i][6], byp[i][4], byp[i][2], byp[i][0]};
      cmp(32'(dout[6:3]), e);
      devrd(REG_BYPASS, byp[i]);
    end
    // Refused shorting write raises an unmasked interrupt
    apb(1'b1, APB_INT_STAT, 32'h3, 1'b0, q);
    apb(1'b1, APB_INT_MASK, 32'h2, 1'b0, q);
    rd(APB_INT_MASK, 32'h3, 32'h2);
    dev(1'b1, REG_BYPASS, 8'h50);
    cmp(32'(irq), 32'h1);
    devrd(REG_BYPASS, 8'h11);
    apb(1'b1, APB_INT_STAT, 32'h2, 1'b0, q);
    @(posedge clk);
    cmp(32'(irq), 32'h0);
    apb(1'b1, APB_INT_MASK, 32'h0, 1'b0, q);
    dev(1'b1, REG_RSVD_LO, 8'($urandom()));
    cmp(32'(irq), 32'h0);
    rd(APB_INT_STAT, 32'h3, 32'h3);
    devrd(REG_RSVD_LO, 8'h00);
    // Every DAC current code
    for (int c = 0; c < 4; c++)
    begin
      v = {2'(c), 6'h00};
      dev(1'b1, REG_DAC_TRIM, v);
      cmp(32'(dout[2:1]), {30'h0, c == 1, c == 3});
      devrd(REG_DAC_TRIM, v);
    end
    // Page one, then back to page zero
    dev(1'b1, REG_PAGE, 8'h01);
    cmp(32'(dout[0]), 32'h1);
    rd(APB_STAT, 32'h2, 32'h2);
    devrd(REG_PAGE, 8'h01);
    devrd(REG_ADC_PATH, 8'h00);
    dev(1'b1, REG_PAGE, 8'h00);
    cmp(32'(dout[0]), 32'h0);
    devrd(REG_PAGE, 8'h00);
    // Hang seen, then cleared by reading
    dev(1'b1, REG_ADC_PATH, 8'h00);
    hang_pulse(seen);
    cmp(32'(seen), 32'h1);
    devrd(REG_ADC_PATH, 8'h01);
    devrd(REG_ADC_PATH, 8'h00);
    // Hang edge lands on the edge of a clearing read
    fork
      dev(1'b0, REG_ADC_PATH, 8'h00);
      begin
        @(posedge clk);
        hang <= 1'b1;
      end
    join
    hang <= 1'b0;
    rd(APB_STAT, 32'h0000FF00, 32'h0);
    devrd(REG_ADC_PATH, 8'h01);
    // Detection off records nothing
    dev(1'b1, REG_ADC_PATH, 8'h04);
    rd(APB_CMD, 32'h0001FF7F, 32'h0001046B);
    hang_pulse(seen);
    cmp(32'(seen), 32'h0);
    devrd(REG_ADC_PATH, 8'h04);
    wrap_up();
  end
endmodule
